// file: hdl/rdpath.sv
// sdram device side: bank open state, auto precharge, read bursts with strobe, write capture
// Behaviour
// RQ1: row must be activated before access
// RQ2: access waits trcd after activate
// RQ3: same bank reopen needs precharge, trc
// RQ4: activates to other banks tRRD apart
// RQ5: at most four activates per tFAW
// RQ6: read carries column, bank, auto precharge
// RQ7: first data RL=AL+CL clocks after read
// RQ8: strobe low preamble and postamble around data
// RQ9: data lines released after burst ends
// RQ10: read BL/2 later gives gapless data
// RQ11: length four reads never interrupted
// RQ12: length eight read truncated only two later
// RQ13: interrupting read any bank, no precharge
// RQ14: read data finishes before write burst
// RQ15: precharge after read meets AL+BL/2, trtp
// RQ16: trtp measured from last prefetch edge
// RQ17: read to precharge AL+BL/2-2+max(trtp,2)
// RQ18: no bank command until trp elapsed
// RQ19: write latency is read latency minus one
// RQ20: auto precharge after AL+BL/2, tras, trtp
// RQ21: controller keeps per bank timing counters
`timescale 1ns/1ps
module rdpath
    import rdpath_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ck_i,
    input wire cmd_s cmd_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe_n_o,
    output logic dqs_o,
    output logic dqs_n_o,
    output logic dqs_oe_n_o,
    output logic [7:0] wr_data_o,
    output logic wr_valid_o
);
    logic [2:0] ck_sync_ff;
    cmd_s cmd_m_ff, cmd_ff;
    logic [7:0] dq_m_ff, dq_s_ff;
    logic ck_rise, ck_fall, is_act, is_rd, is_wr, is_pre;
    logic [2:0] cl_ff, al_ff;
    logic bl8_ff, ack_ff;
    logic [3:0] rl, bl;
    acc_s dl_ff [DL_DEPTH];
    acc_s rd_hit, pre_hit;
    logic [7:0] open_ff;
    logic [7:0] ap_pend_ff;
    logic [7:0] ras_age_ff [8];
    logic [4:0] ap_age_ff [8];
    burst_e st_ff;
    logic [2:0] left_ff, wleft_ff;
    logic [2:0] bank_ff;
    logic [9:0] col_ff;

    // element value derived from its address, stands in for the array contents
    function automatic logic [7:0] elem_of(input logic [2:0] b, input logic [9:0] c);
        elem_of = c[7:0] ^ {b, 5'h00};
    endfunction

    // pins come from another domain: two flops before anything looks at them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ck_sync_ff <= 3'h0;
            cmd_m_ff <= '1;
            cmd_ff <= '1;
            dq_m_ff <= 8'h00;
            dq_s_ff <= 8'h00;
        end else begin
            ck_sync_ff <= {ck_sync_ff[1:0], ck_i};
            cmd_m_ff <= cmd_i;
            cmd_ff <= cmd_m_ff;
            dq_m_ff <= dq_i;
            dq_s_ff <= dq_m_ff;
        end
    end

    // edges are found on the second and third stage only
    assign ck_rise = ck_sync_ff[1] & ~ck_sync_ff[2];
    assign ck_fall = ~ck_sync_ff[1] & ck_sync_ff[2];
    assign is_act = ck_rise & ~cmd_ff.cs_n & ~cmd_ff.ras_n & cmd_ff.cas_n & cmd_ff.we_n;
    assign is_rd = ck_rise & ~cmd_ff.cs_n & cmd_ff.ras_n & ~cmd_ff.cas_n & cmd_ff.we_n;
    assign is_wr = ck_rise & ~cmd_ff.cs_n & cmd_ff.ras_n & ~cmd_ff.cas_n & ~cmd_ff.we_n;
    assign is_pre = ck_rise & ~cmd_ff.cs_n & ~cmd_ff.ras_n & cmd_ff.cas_n & ~cmd_ff.we_n;
    assign rl = 4'({1'b0, al_ff} + {1'b0, cl_ff}); // RQ7
    assign bl = bl8_ff ? 4'h8 : 4'h4;
    assign rd_hit = dl_ff[rl - 4'h1];
    assign pre_hit = dl_ff[rl - 4'h2]; // RQ19

    // wishbone slave: answer one cycle after the strobe, unmapped reads as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            cl_ff <= CL_RST;
            al_ff <= AL_RST;
            bl8_ff <= 1'b0;
        end else begin
            ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
            if (wb_cyc_i && wb_stb_i && !ack_ff && wb_we_i && wb_adr_i == CFG_ADR) begin
                if (wb_sel_i[0]) begin
                    cl_ff <= wb_dat_i[2:0];
                    al_ff <= wb_dat_i[6:4];
                end
                if (wb_sel_i[1]) begin
                    bl8_ff <= wb_dat_i[8];
                end
            end
        end
    end
    assign wb_ack_o = ack_ff;

    // read data is combinational off held registers, valid while ack is high
    always_comb begin
        wb_dat_o = 32'h0000_0000;
        if (wb_adr_i == CFG_ADR) begin
            wb_dat_o = {23'h00_0000, bl8_ff, 1'b0, al_ff, 1'b0, cl_ff};
        end else if (wb_adr_i == STAT_ADR) begin
            wb_dat_o = {14'h0000, st_ff, ap_pend_ff, open_ff};
        end
    end

    // access delay line, one slot per ck period, so reads can overlap in flight
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DL_DEPTH; i++) begin
                dl_ff[i] <= '0;
            end
        end else if (ck_rise) begin
            dl_ff[0] <= '{valid: is_rd | is_wr, wr: is_wr, bank: cmd_ff.ba, col: cmd_ff.a[9:0]}; // RQ6
            for (int i = 1; i < DL_DEPTH; i++) begin
                dl_ff[i] <= dl_ff[i - 1];
            end
        end
    end

    // per bank row state; the close of an auto precharge waits for tras and trtp
    for (genvar b = 0; b < 8; b++) begin : g_bank
        logic ap_due;
        assign ap_due = ap_pend_ff[b]
            && ap_age_ff[b] >= 5'({al_ff, 1'b0} / 2 + bl / 2)
            && ap_age_ff[b] >= 5'(al_ff + (bl8_ff ? 2 : 0) + TRTP_CK)
            && ras_age_ff[b] >= 8'(TRAS_CK); // RQ20
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                open_ff[b] <= 1'b0;
                ap_pend_ff[b] <= 1'b0;
                ras_age_ff[b] <= 8'h00;
                ap_age_ff[b] <= 5'h00;
            end else if (ck_rise) begin
                if (ras_age_ff[b] != 8'hff) begin
                    ras_age_ff[b] <= ras_age_ff[b] + 8'h01;
                end
                if (ap_age_ff[b] != 5'h1f) begin
                    ap_age_ff[b] <= ap_age_ff[b] + 5'h01;
                end
                if (is_act && cmd_ff.ba == 3'(b)) begin
                    open_ff[b] <= 1'b1; // RQ1
                    ras_age_ff[b] <= 8'h00;
                end else if (is_pre && (cmd_ff.a[AP_BIT] || cmd_ff.ba == 3'(b))) begin
                    open_ff[b] <= 1'b0; // RQ15
                    ap_pend_ff[b] <= 1'b0;
                end else if ((is_rd || is_wr) && cmd_ff.ba == 3'(b) && cmd_ff.a[AP_BIT]) begin
                    ap_pend_ff[b] <= 1'b1;
                    ap_age_ff[b] <= 5'h00;
                end else if (ap_due) begin
                    open_ff[b] <= 1'b0;
                    ap_pend_ff[b] <= 1'b0;
                end
            end
        end
        // a close that is not a precharge must wait al + bl/2 ck from its read
        a_ap_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
            $fell(open_ff[b]) && !$past(is_pre) |-> $past(ap_age_ff[b]) >= 5'(al_ff + bl / 2))
            else $error("auto precharge closed early");
    end

    // burst engine: a new burst loaded at its rise replaces any running one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= ST_IDLE;
            left_ff <= 3'h0;
            bank_ff <= 3'h0;
            col_ff <= 10'h000;
            dq_o <= 8'h00;
            dqs_o <= 1'b0;
        end else if (ck_rise) begin
            if (rd_hit.valid && !rd_hit.wr) begin
                st_ff <= ST_DATA; // RQ7 RQ10
                left_ff <= 3'(bl - 4'h1);
                bank_ff <= rd_hit.bank;
                col_ff <= rd_hit.col + 10'h001;
                dq_o <= elem_of(rd_hit.bank, rd_hit.col);
                dqs_o <= 1'b1;
            end else if (st_ff == ST_DATA && left_ff == 3'h0) begin
                st_ff <= ST_POST; // RQ8
                dqs_o <= 1'b0;
            end else if (st_ff == ST_DATA) begin
                left_ff <= left_ff - 3'h1;
                col_ff <= col_ff + 10'h001;
                dq_o <= elem_of(bank_ff, col_ff);
                dqs_o <= 1'b1;
            end else if (pre_hit.valid && !pre_hit.wr) begin
                st_ff <= ST_PRE; // RQ8
                dqs_o <= 1'b0;
            end else begin
                st_ff <= ST_IDLE; // RQ9
                dqs_o <= 1'b0;
            end
        end else if (ck_fall) begin
            if (st_ff == ST_DATA) begin
                left_ff <= left_ff - 3'h1;
                col_ff <= col_ff + 10'h001;
                dq_o <= elem_of(bank_ff, col_ff);
                dqs_o <= 1'b0;
            end else if (st_ff == ST_POST) begin
                st_ff <= ST_IDLE; // RQ9
            end
        end
    end
    // enables are active low while driving; strobe also held through pre and post
    assign dq_oe_n_o = (st_ff != ST_DATA);
    assign dqs_oe_n_o = (st_ff == ST_IDLE);
    assign dqs_n_o = ~dqs_o;

    // write capture one ck before the read latency; one element per ck edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wleft_ff <= 3'h0;
            wr_data_o <= 8'h00;
            wr_valid_o <= 1'b0;
        end else begin
            wr_valid_o <= 1'b0;
            if (ck_rise && pre_hit.valid && pre_hit.wr) begin
                wleft_ff <= 3'(bl - 4'h1); // RQ19
                wr_data_o <= dq_s_ff;
                wr_valid_o <= 1'b1;
            end else if ((ck_rise || ck_fall) && wleft_ff != 3'h0) begin
                wleft_ff <= wleft_ff - 3'h1;
                wr_data_o <= dq_s_ff;
                wr_valid_o <= 1'b1;
            end
        end
    end

    // checks
    // age of the oldest read whose data has not started yet; a read that comes
    // while an earlier one is still in flight must not restart the count
    logic [3:0] rd_age_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_age_ff <= 4'hf;
        end else if (is_rd && rd_age_ff >= rl) begin
            rd_age_ff <= 4'h0;
        end else if (ck_rise && rd_age_ff != 4'hf) begin
            rd_age_ff <= rd_age_ff + 4'h1;
        end
    end
    a_dq_idle_hiz: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
        st_ff == ST_POST && ck_fall |=> dq_oe_n_o && dqs_oe_n_o) else $error("lines driven while idle");
    a_preamble_low: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
        st_ff == ST_PRE |-> !dqs_o && dqs_n_o && dq_oe_n_o) else $error("bad read preamble");
    a_postamble_low: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
        st_ff == ST_POST |-> !dqs_o && !dqs_oe_n_o) else $error("bad read postamble");
    a_read_latency: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
        $rose(st_ff == ST_DATA) && rd_age_ff != 4'hf |-> rd_age_ff == rl)
        else $error("first element not at read latency");
    a_data_follows: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
        ck_rise && rd_hit.valid && !rd_hit.wr |=> st_ff == ST_DATA && dqs_o
        && dq_o == elem_of($past(rd_hit.bank), $past(rd_hit.col))) else $error("burst not loaded");
    a_act_opens: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
        is_act |=> open_ff[$past(cmd_ff.ba)]) else $error("activate left bank closed");
    a_pre_closes: assert property (@(posedge clk_i) disable iff (rst_i) // RQ15
        is_pre && !cmd_ff.a[AP_BIT] |=> !open_ff[$past(cmd_ff.ba)]) else $error("precharge kept row");
    a_ap_early: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
        is_rd && cmd_ff.a[AP_BIT] && open_ff[cmd_ff.ba] |=> open_ff[$past(cmd_ff.ba)])
        else $error("auto precharge closed at command");
    a_write_valid: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
        ck_rise && pre_hit.valid && pre_hit.wr |=> wr_valid_o && wr_data_o == $past(dq_s_ff))
        else $error("write capture missed");
    // the postamble must follow the last element unless a new burst takes over
    a_post_follows: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
        ck_rise && st_ff == ST_DATA && left_ff == 3'h0 && !(rd_hit.valid && !rd_hit.wr)
        |=> st_ff == ST_POST && !dqs_o && !dqs_oe_n_o) else $error("postamble missing");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
    c_gapless: cover property (@(posedge clk_i) disable iff (rst_i)
        ck_rise && rd_hit.valid && st_ff == ST_DATA && left_ff == 3'h0);
    c_truncate: cover property (@(posedge clk_i) disable iff (rst_i)
        ck_rise && rd_hit.valid && st_ff == ST_DATA && left_ff != 3'h0);
    c_ap_close: cover property (@(posedge clk_i) disable iff (rst_i) $fell(|ap_pend_ff));
endmodule

// file: hdl/rdpath_pkg.sv
// shared constants and types for the sdram activate and read timing block
package rdpath_pkg;
    localparam int CK_NS = 125;
    localparam int TRAS_NS = 40;
    localparam int TRTP_NS = 8;
    localparam int TRAS_CK = (TRAS_NS + CK_NS - 1) / CK_NS;
    localparam int TRTP_CK = (TRTP_NS + CK_NS - 1) / CK_NS;
    localparam int DL_DEPTH = 16;
    localparam logic [7:0] CFG_ADR = 8'h00;
    localparam logic [7:0] STAT_ADR = 8'h04;
    localparam logic [2:0] CL_RST = 3'h3;
    localparam logic [2:0] AL_RST = 3'h0;
    localparam int AP_BIT = 10;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [14:0] a;
    } cmd_s;
    typedef struct packed {
        logic valid;
        logic wr;
        logic [2:0] bank;
        logic [9:0] col;
    } acc_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRE = 2'b01,
        ST_DATA = 2'b10,
        ST_POST = 2'b11
    } burst_e;
endpackage

// file: bench/ctrl_model.sv
// controller model: free memory clock, command pins, read capture, write data drive
`timescale 1ns/1ps
module ctrl_model
    import rdpath_pkg::*;
(
    input wire logic clk_i,
    output logic ck_o,
    output cmd_s cmd_o,
    output logic [7:0] dq_o,
    input wire logic [7:0] dq_i,
    input wire logic dq_oe_n_i,
    input wire logic dqs_i,
    input wire logic dqs_oe_n_i
);
    logic [7:0] cap[$];
    int ck_cnt = 0;
    int rd_ck = 0;
    int lat = 0;
    int runs = 0;
    time pre_t = 0;
    time pre_len = 0;
    logic dqs_q = 1'b0;
    logic oe_q = 1'b1;
    logic soe_q = 1'b1;
    logic post_ok = 1'b0;
    // memory clock runs free; the quarter ns offset keeps its edges off the clk_i grid
    initial begin
        ck_o = 1'b0;
        cmd_o = '1;
        dq_o = 8'h00;
        #0.25;
        forever #62.5 ck_o = ~ck_o;
    end
    always @(posedge ck_o) ck_cnt++;
    // one command per call, held from the ck fall before its rise to the fall after;
    // gaps=1 gives two ck between commands, which covers trcd, trrd and bl/2 spacing at length four
    task automatic send(input logic [3:0] op, input logic [2:0] ba, input logic [14:0] a, input int gaps);
        repeat (gaps) @(negedge ck_o);
        @(posedge clk_i) cmd_o <= {1'b0, op[2:0], ba, a};
        @(posedge ck_o);
        @(posedge clk_i) rd_ck = ck_cnt;
        @(negedge ck_o);
        @(posedge clk_i) cmd_o <= {4'h7, 3'h0, 15'h0000};
    endtask
    // element k is put up half a ck before the edge that takes it; the last one is then inverted
    task automatic wdata(input int rl, input int bl, input logic [7:0] base);
        repeat (rl - 2) @(posedge ck_o);
        @(negedge ck_o);
        for (int k = 0; k < bl; k++) begin
            @(posedge clk_i) dq_o <= base + 8'(k);
            @(ck_o);
        end
        @(posedge clk_i) dq_o <= ~(base + 8'(bl - 1));
    endtask
    // first element of a run gives latency and preamble length; run end checks postamble
    always @(posedge clk_i) begin
        if (dqs_oe_n_i === 1'b0 && soe_q !== 1'b0) pre_t = $time;
        if (dq_oe_n_i === 1'b0 && dqs_i !== dqs_q) begin
            if (oe_q !== 1'b0) begin
                runs++;
                lat = ck_cnt - rd_ck;
                pre_len = $time - pre_t;
            end
            cap.push_back(dq_i);
        end
        if (dq_oe_n_i === 1'b1 && oe_q === 1'b0) post_ok = (dqs_oe_n_i === 1'b0 && dqs_i === 1'b0);
        dqs_q = dqs_i;
        oe_q = dq_oe_n_i;
        soe_q = dqs_oe_n_i;
    end
endmodule

// file: bench/rdpath_tb_top.sv
// testbench: registers, read bursts, gapless and truncated reads, write capture
`timescale 1ns/1ps
module rdpath_tb_top
    import rdpath_pkg::*;
;
    typedef struct packed {
        logic [2:0] cl;
        logic [2:0] al;
        logic bl8;
        logic ap;
        logic [2:0] ba;
        logic [9:0] col;
    } row_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, ck, dq_oe_n_o, dqs_o, dqs_n_o, dqs_oe_n_o, wr_valid_o;
    cmd_s cmd;
    logic [7:0] rd_dq, md_dq, dq_w, wr_data_o;
    logic [7:0] wq[$];
    int fail_count = 0;
    int num_checks = 0;
    int rl, bl;
    row_s rows[4] = '{{3'h3, 3'h0, 1'b0, 1'b0, 3'h0, 10'h010}, {3'h4, 3'h1, 1'b1, 1'b1, 3'h5, 10'h0fc},
        {3'h5, 3'h2, 1'b0, 1'b1, 3'h7, 10'h2fe}, {3'h3, 3'h3, 1'b1, 1'b0, 3'h2, 10'h155}};
    // the dq wire: device drives it only while its enable is low
    assign dq_w = (dq_oe_n_o == 1'b0) ? rd_dq : md_dq;
    rdpath dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ck_i(ck), .cmd_i(cmd), .dq_i(dq_w), .dq_o(rd_dq), .dq_oe_n_o(dq_oe_n_o), .dqs_o(dqs_o),
        .dqs_n_o(dqs_n_o), .dqs_oe_n_o(dqs_oe_n_o), .wr_data_o(wr_data_o), .wr_valid_o(wr_valid_o));
    ctrl_model ctl (.clk_i(clk_i), .ck_o(ck), .cmd_o(cmd), .dq_o(md_dq), .dq_i(dq_w),
        .dq_oe_n_i(dq_oe_n_o), .dqs_i(dqs_o), .dqs_oe_n_i(dqs_oe_n_o));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    function automatic logic [7:0] ev(input logic [2:0] ba, input logic [9:0] col, input int k);
        logic [9:0] c;
        c = col + 10'(k);
        return c[7:0] ^ {ba, 5'h00};
    endfunction
    task automatic cmpq(input int off, input logic [2:0] ba, input logic [9:0] col, input int n);
        for (int k = 0; k < n; k++) chk(32'(ctl.cap[off + k]), 32'(ev(ba, col, k)));
    endtask
    task automatic cfg(input logic [2:0] cl, input logic [2:0] al, input logic b8);
        logic [31:0] d;
        d = {23'h0, b8, 1'b0, al, 1'b0, cl};
        rl = int'(cl) + int'(al);
        bl = b8 ? 8 : 4;
        wb(1'b1, CFG_ADR, d, q);
        wb(1'b0, CFG_ADR, 32'h0000_0000, q);
        chk(q, d);
        ctl.cap.delete();
        ctl.runs = 0;
        ctl.post_ok = 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ck);
        @(posedge clk_i);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_i) if (wr_valid_o === 1'b1) wq.push_back(wr_data_o);
    always @(posedge clk_i) if (dqs_oe_n_o === 1'b0 && dqs_n_o === dqs_o) chk(32'(dqs_n_o), 32'(!dqs_o));
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CFG_ADR, 32'h0000_0000, q);
        chk(q, 32'({AL_RST, 1'b0, CL_RST}));
        wb(1'b1, STAT_ADR, 32'hffff_ffff, q);
        wb(1'b0, STAT_ADR, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        wb(1'b1, 8'h08, 32'h1234_5678, q);
        wb(1'b0, 8'h08, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        $display("test regs done");
        // one plain read per row: latency, data, strobe, release and row state
        foreach (rows[i]) begin
            cfg(rows[i].cl, rows[i].al, rows[i].bl8);
            ctl.send(4'h3, rows[i].ba, 15'h0123, 1);
            ctl.send(4'h5, rows[i].ba, {4'h0, rows[i].ap, rows[i].col}, 1);
            wt(rl + bl / 2 + 4);
            chk(32'(ctl.cap.size()), 32'(bl));
            cmpq(0, rows[i].ba, rows[i].col, bl);
            chk(32'(ctl.lat), 32'(rl));
            chk(32'(ctl.pre_len >= 100), 32'h0000_0001);
            chk(32'(ctl.post_ok), 32'h0000_0001);
            chk(32'({dq_oe_n_o, dqs_oe_n_o}), 32'h0000_0003);
            wb(1'b0, STAT_ADR, 32'h0000_0000, q);
            chk(32'(q[rows[i].ba]), 32'(!rows[i].ap));
            ctl.send(4'h2, 3'h0, 15'h0400, 1);
            $display("test row %0d done", i);
        end
        // reads bl/2 apart run on without a break
        cfg(3'h3, 3'h0, 1'b0);
        ctl.send(4'h3, 3'h1, 15'h0042, 3);
        ctl.send(4'h5, 3'h1, 15'h0020, 1);
        ctl.send(4'h5, 3'h1, 15'h0040, 1);
        wt(rl + 6);
        chk(32'(ctl.runs), 32'h0000_0001);
        chk(32'(ctl.cap.size()), 32'h0000_0008);
        cmpq(0, 3'h1, 10'h020, 4);
        cmpq(4, 3'h1, 10'h040, 4);
        $display("test gapless done");
        // length eight read cut after four elements by a read two ck later
        cfg(3'h3, 3'h0, 1'b1);
        ctl.send(4'h3, 3'h6, 15'h0011, 3);
        ctl.send(4'h5, 3'h1, 15'h0080, 1);
        ctl.send(4'h5, 3'h6, 15'h0090, 1);
        wt(rl + 9);
        chk(32'(ctl.cap.size()), 32'h0000_000c);
        cmpq(0, 3'h1, 10'h080, 4);
        cmpq(4, 3'h6, 10'h090, 8);
        $display("test truncate done");
        // write data taken from one ck before read latency
        cfg(3'h4, 3'h0, 1'b0);
        wq.delete();
        ctl.send(4'h4, 3'h1, 15'h0010, 3);
        ctl.wdata(rl, 4, 8'ha0);
        wt(3);
        chk(32'(wq.size()), 32'h0000_0004);
        for (int k = 0; k < 4; k++) chk(32'(wq[k]), 32'(8'ha0 + 8'(k)));
        $display("test write done");
        // reset in mid-run: settings and row state must fall back to reset values
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CFG_ADR, 32'h0000_0000, q);
        chk(q, 32'({AL_RST, 1'b0, CL_RST}));
        wb(1'b0, STAT_ADR, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        $display("test reset done");
        complete_run();
    end
endmodule
